// [design/i2c_ext_status.sv]
// extended status, bus control state and interrupt queue of the i2c interface
// Notes on behaviour
// - bus state codes 001, 010, 011 reported
// - free 100, busy 101, reset value 110
// - codes 000 and 111 never produced
// - pending set when active and on-deck full
// - pending moves on-deck after on-deck promotes
// - on-deck set on event while active
// - pending fills free on-deck next cycle
// - clearing active promotes on-deck to active
// - active stays until software clears it
// - write one clears queue and error flags
// - arbitration loss sets arbitration-lost flag
// - partial master transfer sets incomplete flag
// - abort event sets aborted, lost arbitration does not
// - pending transfer clears the three error flags
// - arbitration lost in repeated start drops ownership
// - main error bit is or of error flags
// - interrupt disabled never sets active flag
`timescale 1ns/1ns
`default_nettype none
module i2c_ext_status
  import i2c_ext_status_pkg::*;
(
  // clock and reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 srst,
  // register port
  input  wire logic [i2c_ext_status_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [i2c_ext_status_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [i2c_ext_status_pkg::DATA_W-1:0] reg_rdata,
  // bus events from the protocol engine
  input  wire logic                                 start_seen,
  input  wire logic                                 stop_seen,
  input  wire logic                                 master_start,
  input  wire logic                                 slave_addr_match,
  input  wire logic                                 slave_addr_miss,
  input  wire logic                                 exit_unknown_req,
  // transfer outcome from the protocol engine
  input  wire logic                                 pending_transfer_flag,
  input  wire logic                                 arb_lost_evt,
  input  wire logic                                 incomplete_evt,
  input  wire logic                                 abort_evt,
  input  wire logic                                 irq_condition,
  // interrupt
  output logic                                      irq
);
  import i2c_ext_status_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bus_state_type           bus_state;
    logic                    irq_active_flag;
    logic                    irq_on_deck_flag;
    logic                    irq_pending_flag;
    logic                    arbitration_lost_flag;
    logic                    incomplete_transfer_flag;
    logic                    transfer_aborted_flag;
    logic                    interrupt_enable_bit;
    logic [EVT_N-1:0]        evt_status;
    logic [EVT_N-1:0]        evt_mask;
    logic [DATA_W-1:0]       rdata;
    logic                    irq;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic [2:0]        state_code;
  logic [DATA_W-1:0] ext_vec;
  logic [DATA_W-1:0] main_vec;
  logic [DATA_W-1:0] ctrl_vec;
  logic [DATA_W-1:0] evt_vec;
  logic [DATA_W-1:0] mask_vec;
  logic              wr_main;
  logic              wr_ext;
  logic              wr_evt;
  logic              clr_active;
  logic              queue_evt;
  logic [EVT_N-1:0]  evt_set;

  // ----------------------------------------
  // status views
  // ----------------------------------------
  always_comb begin
    case (s_r.bus_state)
      ST_SLAVE_SEL:  state_code = CODE_SLAVE_SEL;
      ST_SLAVE_XFER: state_code = CODE_SLAVE_XFER;
      ST_MASTER:     state_code = CODE_MASTER;
      ST_FREE:       state_code = CODE_FREE;
      ST_BUSY:       state_code = CODE_BUSY;
      default:       state_code = CODE_UNKNOWN;
    endcase
  end

  always_comb begin
    // msb-first numbering: documented bit 0 is vector bit 7
    ext_vec                        = ZERO_BYTE;
    ext_vec[EXT_PEND]                  = s_r.irq_pending_flag;
    ext_vec[EXT_STATE_HI:EXT_STATE_LO] = state_code;
    ext_vec[EXT_DECK]                  = s_r.irq_on_deck_flag;
    ext_vec[EXT_ARB]                   = s_r.arbitration_lost_flag;
    ext_vec[EXT_PART]                  = s_r.incomplete_transfer_flag;
    ext_vec[EXT_ABORT]                 = s_r.transfer_aborted_flag;
    main_vec                       = ZERO_BYTE;
    main_vec[MAIN_ERR]             = s_r.arbitration_lost_flag
                                   | s_r.incomplete_transfer_flag
                                   | s_r.transfer_aborted_flag;
    main_vec[MAIN_ACTIVE]          = s_r.irq_active_flag;
    main_vec[MAIN_XFER]            = pending_transfer_flag;
    ctrl_vec                       = ZERO_BYTE;
    ctrl_vec[CTRL_IRQ_EN]          = s_r.interrupt_enable_bit;
    evt_vec                        = ZERO_BYTE;
    evt_vec[EVT_N-1:0]             = s_r.evt_status;
    mask_vec                       = ZERO_BYTE;
    mask_vec[EVT_N-1:0]            = s_r.evt_mask;
  end

  assign wr_main    = reg_wr && (reg_addr == OFS_MAIN_STATUS);
  assign wr_ext     = reg_wr && (reg_addr == OFS_EXT_STATUS);
  assign wr_evt     = reg_wr && (reg_addr == OFS_EVT_STATUS);
  assign clr_active = wr_main && reg_wdata[MAIN_ACTIVE];
  // with interrupts disabled no condition ever reaches the queue
  assign queue_evt  = irq_condition && s_r.interrupt_enable_bit;

  always_comb begin
    evt_set            = EVT_RESET;
    evt_set[EVT_QUEUE] = queue_evt;
    evt_set[EVT_ARB]   = arb_lost_evt;
    evt_set[EVT_PART]  = incomplete_evt;
    evt_set[EVT_ABORT] = abort_evt;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;

    // bus control state machine
    case (s_r.bus_state)
      ST_UNKNOWN: begin
        if (exit_unknown_req || stop_seen) begin
          s_nxt.bus_state = ST_FREE;
        end
      end
      ST_FREE: begin
        if (master_start) begin
          s_nxt.bus_state = ST_MASTER;
        end else if (start_seen) begin
          s_nxt.bus_state = ST_SLAVE_XFER;
        end
      end
      ST_BUSY: begin
        if (stop_seen) begin
          s_nxt.bus_state = ST_FREE;
        end
      end
      ST_MASTER: begin
        // a lost arbitration, even at a repeated start, leaves the bus to another master
        if (arb_lost_evt) begin
          s_nxt.bus_state = ST_BUSY;
        end else if (stop_seen) begin
          s_nxt.bus_state = ST_FREE;
        end
      end
      ST_SLAVE_XFER: begin
        if (stop_seen) begin
          s_nxt.bus_state = ST_FREE;
        end else if (slave_addr_match) begin
          s_nxt.bus_state = ST_SLAVE_SEL;
        end else if (slave_addr_miss) begin
          s_nxt.bus_state = ST_BUSY;
        end
      end
      ST_SLAVE_SEL: begin
        if (stop_seen) begin
          s_nxt.bus_state = ST_FREE;
        end
      end
      default: begin
        s_nxt.bus_state = ST_UNKNOWN;
      end
    endcase

    // interrupt queue: active, on-deck, pending
    if (clr_active) begin
      // on-deck entry takes over the active slot
      s_nxt.irq_active_flag  = s_r.irq_on_deck_flag;
      s_nxt.irq_on_deck_flag = 1'b0;
    end
    if (wr_ext && reg_wdata[EXT_PEND]) begin
      s_nxt.irq_pending_flag = 1'b0;
    end
    if (wr_ext && reg_wdata[EXT_DECK]) begin
      s_nxt.irq_on_deck_flag = 1'b0;
    end
    // pending advances a cycle after on-deck frees up
    if (s_r.irq_pending_flag && !s_r.irq_on_deck_flag && !clr_active) begin
      s_nxt.irq_on_deck_flag = 1'b1;
      s_nxt.irq_pending_flag = 1'b0;
    end
    // new condition lands in the first free stage; set beats a clear
    if (queue_evt) begin
      if (!s_nxt.irq_active_flag) begin
        s_nxt.irq_active_flag = 1'b1;
      end else if (!s_nxt.irq_on_deck_flag) begin
        s_nxt.irq_on_deck_flag = 1'b1;
      end else begin
        s_nxt.irq_pending_flag = 1'b1;
      end
    end
    // no self clear of the active slot
    if (!s_nxt.irq_active_flag) begin
      s_nxt.irq_on_deck_flag = 1'b0;
    end

    // error flags: a new transfer clears them, events still win
    if (pending_transfer_flag) begin
      s_nxt.arbitration_lost_flag    = 1'b0;
      s_nxt.incomplete_transfer_flag = 1'b0;
      s_nxt.transfer_aborted_flag    = 1'b0;
    end
    if (wr_ext && reg_wdata[EXT_ARB]) begin
      s_nxt.arbitration_lost_flag = 1'b0;
    end
    if (wr_ext && reg_wdata[EXT_PART]) begin
      s_nxt.incomplete_transfer_flag = 1'b0;
    end
    if (wr_ext && reg_wdata[EXT_ABORT]) begin
      s_nxt.transfer_aborted_flag = 1'b0;
    end
    if (arb_lost_evt) begin
      s_nxt.arbitration_lost_flag = 1'b1;
    end
    if (incomplete_evt) begin
      s_nxt.incomplete_transfer_flag = 1'b1;
    end
    if (abort_evt) begin
      s_nxt.transfer_aborted_flag = 1'b1;
    end

    // control and event registers
    if (reg_wr && (reg_addr == OFS_MODE_CTRL)) begin
      s_nxt.interrupt_enable_bit = reg_wdata[CTRL_IRQ_EN];
    end
    if (reg_wr && (reg_addr == OFS_EVT_MASK)) begin
      s_nxt.evt_mask = reg_wdata[EVT_N-1:0];
    end
    s_nxt.evt_status = (s_r.evt_status & ~(wr_evt ? reg_wdata[EVT_N-1:0] : EVT_RESET))
                     | evt_set;
    s_nxt.irq = |(s_nxt.evt_status & s_nxt.evt_mask);

    // read port, data valid the cycle after the strobe only
    s_nxt.rdata = ZERO_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        OFS_MAIN_STATUS: s_nxt.rdata = main_vec;
        OFS_EXT_STATUS:  s_nxt.rdata = ext_vec;
        OFS_MODE_CTRL:   s_nxt.rdata = ctrl_vec;
        OFS_EVT_STATUS:  s_nxt.rdata = evt_vec;
        OFS_EVT_MASK:    s_nxt.rdata = mask_vec;
        default:         s_nxt.rdata = ZERO_BYTE;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r.bus_state                <= ST_UNKNOWN;
      s_r.irq_active_flag          <= 1'b0;
      s_r.irq_on_deck_flag         <= 1'b0;
      s_r.irq_pending_flag         <= 1'b0;
      s_r.arbitration_lost_flag    <= 1'b0;
      s_r.incomplete_transfer_flag <= 1'b0;
      s_r.transfer_aborted_flag    <= 1'b0;
      s_r.interrupt_enable_bit     <= 1'b0;
      s_r.evt_status               <= EVT_RESET;
      s_r.evt_mask                 <= EVT_RESET;
      s_r.rdata                    <= ZERO_BYTE;
      s_r.irq                      <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign irq       = s_r.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  state_code_legal_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state_code != CODE_BAD_LO) && (state_code != CODE_BAD_HI))
    else $error("bus control state shows an unused code");

  state_reset_unknown_a: assert property (
    @(posedge ref_clk) $past(srst) |-> (state_code == CODE_UNKNOWN))
    else $error("bus control state not unknown after reset");

  master_code_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (s_r.bus_state == ST_FREE) && master_start |=> (state_code == CODE_MASTER))
    else $error("master start did not report master code");

  arb_drops_master_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (s_r.bus_state == ST_MASTER) && arb_lost_evt
      |=> (state_code == CODE_BUSY) && s_r.arbitration_lost_flag)
    else $error("lost arbitration kept master state");

  pending_to_deck_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_r.irq_pending_flag && !s_r.irq_on_deck_flag && !reg_wr
      |=> s_r.irq_on_deck_flag && (s_r.irq_pending_flag == $past(queue_evt)))
    else $error("pending entry did not move on-deck");

  deck_on_event_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    queue_evt && s_r.irq_active_flag && !s_r.irq_on_deck_flag && !reg_wr
      |=> s_r.irq_on_deck_flag)
    else $error("event while active did not fill on-deck");

  pend_on_full_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    queue_evt && s_r.irq_active_flag && s_r.irq_on_deck_flag && !reg_wr
      |=> s_r.irq_pending_flag)
    else $error("event with full queue did not set pending");

  w1c_clears_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    wr_ext && reg_wdata[EXT_ARB] && !arb_lost_evt
      |=> !s_r.arbitration_lost_flag)
    else $error("write one did not clear arbitration-lost flag");

  abort_sets_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    abort_evt |=> s_r.transfer_aborted_flag)
    else $error("abort event did not set aborted flag");

  active_held_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    s_r.irq_active_flag && !clr_active |=> s_r.irq_active_flag)
    else $error("active interrupt dropped without a clear");

  promote_deck_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clr_active && s_r.irq_on_deck_flag |=> s_r.irq_active_flag)
    else $error("on-deck entry not promoted on clear");

  disabled_no_active_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !s_r.interrupt_enable_bit && !s_r.irq_active_flag |=> !s_r.irq_active_flag)
    else $error("active flag set while interrupts disabled");

  xfer_clears_err_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    pending_transfer_flag && !arb_lost_evt && !incomplete_evt && !abort_evt
      |=> !(s_r.arbitration_lost_flag || s_r.incomplete_transfer_flag
            || s_r.transfer_aborted_flag))
    else $error("error flags survived a pending transfer");

  err_summary_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    reg_rd && (reg_addr == OFS_MAIN_STATUS)
      |=> reg_rdata[MAIN_ERR] == $past(s_r.arbitration_lost_flag
          || s_r.incomplete_transfer_flag || s_r.transfer_aborted_flag))
    else $error("main error bit disagrees with error flags");

  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    irq == |($past(s_nxt.evt_status) & $past(s_nxt.evt_mask)))
    else $error("interrupt output disagrees with status and mask");

endmodule : i2c_ext_status
`default_nettype wire

// [design/i2c_ext_status_pkg.sv]
// constants, register map and types of the i2c extended status block
package i2c_ext_status_pkg;

  // ----------------------------------------
  // register port geometry
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MAIN_STATUS = 8'h00;
  localparam logic [7:0] OFS_EXT_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h08;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h10;

  // ----------------------------------------
  // bit positions (msb-first bit n sits at vector bit 7-n)
  // ----------------------------------------
  localparam int EXT_PEND = 7;
  localparam int EXT_STATE_HI = 6;
  localparam int EXT_STATE_LO = 4;
  localparam int EXT_DECK = 3;
  localparam int EXT_ARB = 2;
  localparam int EXT_PART = 1;
  localparam int EXT_ABORT = 0;
  localparam int MAIN_ERR = 2;
  localparam int MAIN_ACTIVE = 1;
  localparam int MAIN_XFER = 0;
  localparam int CTRL_IRQ_EN = 2;
  localparam int EVT_QUEUE = 0;
  localparam int EVT_ARB = 1;
  localparam int EVT_PART = 2;
  localparam int EVT_ABORT = 3;
  localparam int EVT_N = 4;

  // ----------------------------------------
  // reset values and bus control state codes
  // ----------------------------------------
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam logic [2:0] CODE_SLAVE_SEL  = 3'h1;
  localparam logic [2:0] CODE_SLAVE_XFER = 3'h2;
  localparam logic [2:0] CODE_MASTER     = 3'h3;
  localparam logic [2:0] CODE_FREE       = 3'h4;
  localparam logic [2:0] CODE_BUSY       = 3'h5;
  localparam logic [2:0] CODE_UNKNOWN    = 3'h6;
  localparam logic [2:0] CODE_BAD_LO     = 3'h0;
  localparam logic [2:0] CODE_BAD_HI     = 3'h7;

  typedef enum logic [5:0] {
    ST_UNKNOWN    = 6'b000001,
    ST_FREE       = 6'b000010,
    ST_BUSY       = 6'b000100,
    ST_MASTER     = 6'b001000,
    ST_SLAVE_XFER = 6'b010000,
    ST_SLAVE_SEL  = 6'b100000
  } bus_state_type;

endpackage : i2c_ext_status_pkg

// [verification/i2c_bus_events.sv]
// far-side bus model: start, stop, address and outcome events as the engine reports them
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_events (
  // clock
  input  wire logic       ref_clk,
  // command from the bench
  input  wire logic [2:0] op,
  input  wire logic       go,
  // events seen by the protocol engine
  output logic            start_seen,
  output logic            stop_seen,
  output logic            master_start,
  output logic            slave_addr_match,
  output logic            slave_addr_miss,
  output logic            arb_lost_evt,
  output logic            incomplete_evt,
  output logic            abort_evt
);
  logic [7:0] ev_r = 8'h00;

  // -----------------------
  // one pulse per command
  // -----------------------
  // a real bus never shows two conditions in one cycle, so one-hot only
  always_ff @(posedge ref_clk) begin
    ev_r <= go ? (8'h01 << op) : 8'h00;
  end
  assign {abort_evt, incomplete_evt, arb_lost_evt, slave_addr_miss,
          slave_addr_match, master_start, stop_seen, start_seen} = ev_r;
endmodule : i2c_bus_events
`default_nettype wire

// [verification/i2c_extended_status_irq_queue_bench.sv]
// self-checking bench of the i2c extended status and interrupt queue block
`timescale 1ns/1ns
`default_nettype none
module i2c_extended_status_irq_queue_bench;
  import i2c_ext_status_pkg::*;

  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       start_seen, stop_seen, master_start, slave_addr_match, slave_addr_miss;
  logic       arb_lost_evt, incomplete_evt, abort_evt, irq;
  logic       exit_unknown_req = 1'b0;
  logic       pending_transfer_flag = 1'b0;
  logic       irq_condition = 1'b0;
  logic [2:0] op = 3'h0;
  logic       go = 1'b0;
  int         n_fail = 0;
  int         comparisons = 0;
  // start match stop start miss stop master arb stop master stop incomplete abort
  logic [2:0] ops [13] = '{3'h0, 3'h3, 3'h1, 3'h0, 3'h4, 3'h1, 3'h2, 3'h5, 3'h1,
                           3'h2, 3'h1, 3'h6, 3'h7};
  logic [7:0] exps [13] = '{8'h20, 8'h10, 8'h40, 8'h20, 8'h50, 8'h40, 8'h30, 8'h54,
                            8'h44, 8'h34, 8'h44, 8'h46, 8'h47};

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  i2c_ext_status dut (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_seen(start_seen),
    .stop_seen(stop_seen), .master_start(master_start), .slave_addr_match(slave_addr_match),
    .slave_addr_miss(slave_addr_miss), .exit_unknown_req(exit_unknown_req),
    .pending_transfer_flag(pending_transfer_flag), .arb_lost_evt(arb_lost_evt),
    .incomplete_evt(incomplete_evt), .abort_evt(abort_evt), .irq_condition(irq_condition),
    .irq(irq));

  i2c_bus_events bus (
    .ref_clk(ref_clk), .op(op), .go(go), .start_seen(start_seen), .stop_seen(stop_seen),
    .master_start(master_start), .slave_addr_match(slave_addr_match),
    .slave_addr_miss(slave_addr_miss), .arb_lost_evt(arb_lost_evt),
    .incomplete_evt(incomplete_evt), .abort_evt(abort_evt));

  // -----------------------
  // access and compare tasks
  // -----------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rc

  task automatic ev(input logic [2:0] c);
    @(posedge ref_clk);
    op <= c;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
  endtask : ev

  // n back-to-back conditions, one queue entry per cycle
  task automatic cond(input int n);
    @(posedge ref_clk);
    irq_condition <= 1'b1;
    repeat (n) @(posedge ref_clk);
    irq_condition <= 1'b0;
  endtask : cond

  task automatic ci(input logic [7:0] exp);
    @(posedge ref_clk);
    #1 chk({7'h00, irq}, exp);
  endtask : ci

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // -----------------------
  // watchdog
  // -----------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  // -----------------------
  // tests
  // -----------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rc(OFS_EXT_STATUS, 8'h60);
    rc(OFS_MAIN_STATUS, 8'h00);
    rc(8'h20, 8'h00);
    @(posedge ref_clk);
    exit_unknown_req <= 1'b1;
    @(posedge ref_clk);
    exit_unknown_req <= 1'b0;
    rc(OFS_EXT_STATUS, 8'h40);
    for (int i = 0; i < 13; i++) begin
      ev(ops[i]);
      rc(OFS_EXT_STATUS, exps[i]);
    end
    rc(OFS_MAIN_STATUS, 8'h04);
    rc(OFS_EVT_STATUS, 8'h0E);
    wr(OFS_EXT_STATUS, 8'h00);
    rc(OFS_EXT_STATUS, 8'h47);
    wr(OFS_EXT_STATUS, 8'h04);
    rc(OFS_EXT_STATUS, 8'h43);
    @(posedge ref_clk);
    pending_transfer_flag <= 1'b1;
    rc(OFS_EXT_STATUS, 8'h40);
    rc(OFS_MAIN_STATUS, 8'h01);
    @(posedge ref_clk);
    pending_transfer_flag <= 1'b0;
    ev(3'h6);
    wr(OFS_EXT_STATUS, 8'h02);
    rc(OFS_EXT_STATUS, 8'h40);
    wr(OFS_EVT_STATUS, 8'h0E);
    rc(OFS_EVT_STATUS, 8'h00);
    // interrupts still disabled: the condition must not queue
    cond(1);
    rc(OFS_MAIN_STATUS, 8'h00);
    wr(OFS_MODE_CTRL, 8'h04);
    rc(OFS_MODE_CTRL, 8'h04);
    wr(OFS_EVT_MASK, 8'h01);
    cond(3);
    ci(8'h01);
    rc(OFS_EXT_STATUS, 8'hC8);
    repeat (20) @(posedge ref_clk);
    rc(OFS_MAIN_STATUS, 8'h02);
    wr(OFS_MAIN_STATUS, 8'h02);
    rc(OFS_EXT_STATUS, 8'h48);
    rc(OFS_MAIN_STATUS, 8'h02);
    wr(OFS_MAIN_STATUS, 8'h02);
    rc(OFS_EXT_STATUS, 8'h40);
    rc(OFS_MAIN_STATUS, 8'h02);
    wr(OFS_MAIN_STATUS, 8'h02);
    rc(OFS_MAIN_STATUS, 8'h00);
    cond(3);
    wr(OFS_EXT_STATUS, 8'h88);
    rc(OFS_EXT_STATUS, 8'h40);
    wr(OFS_MAIN_STATUS, 8'h02);
    rc(OFS_MAIN_STATUS, 8'h00);
    // status sticky, mask gates the line, write one clears
    rc(OFS_EVT_STATUS, 8'h01);
    wr(OFS_EVT_STATUS, 8'h01);
    ci(8'h00);
    wr(OFS_EVT_MASK, 8'h00);
    cond(1);
    ci(8'h00);
    wr(OFS_EVT_MASK, 8'h01);
    ci(8'h01);
    wr(OFS_EVT_STATUS, 8'h01);
    ci(8'h00);
    print_verdict();
  end
endmodule : i2c_extended_status_irq_queue_bench
`default_nettype wire
